// ### core/eirq_pkg.sv
/*
 * Constants for the external interrupt flag logic: register offsets,
 * field positions and reset values.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
// Functional notes
// - Edge mode clears irq b pending when the core vectors to its routine.
// - Level mode sets irq b pending while its input is active.
// - Irq b trigger type bit selects level or edge detection.
// - Trigger type 0 means level, 1 means edge.
// - Irq b active level comes from polarity bit in config register.
// - Edge mode clears irq a pending when the core vectors to its routine.
// - Level mode sets irq a pending while its input is active.
// - Irq b pending is set by hardware on detected edge or level.
package eirq_pkg;
    // ========================================================
    // Register offsets (byte addresses).
    localparam logic [7:0] EIRQ_OFS_CTRL   = 8'h00;
    localparam logic [7:0] EIRQ_OFS_CFG    = 8'h04;
    localparam logic [7:0] EIRQ_OFS_STATUS = 8'h08;
    localparam logic [7:0] EIRQ_OFS_MASK   = 8'h0c;
    // ========================================================
    // Field positions in timer_irq_control.
    localparam int EIRQ_BIT_A_TYPE = 0;
    localparam int EIRQ_BIT_A_PEND = 1;
    localparam int EIRQ_BIT_B_TYPE = 2;
    localparam int EIRQ_BIT_B_PEND = 3;
    // Field positions in ext_irq_config_reg (1 = active high).
    localparam int EIRQ_BIT_A_POL  = 0;
    localparam int EIRQ_BIT_B_POL  = 1;
    // Event bits in status and mask registers.
    localparam int EIRQ_EV_A       = 0;
    localparam int EIRQ_EV_B       = 1;
    // ========================================================
    // Reset values.
    localparam logic [7:0] EIRQ_RST_CTRL = 8'h00;
    localparam logic [1:0] EIRQ_RST_CFG  = 2'h0;
    localparam logic [1:0] EIRQ_RST_MASK = 2'h0;
    // Trigger type encoding.
    localparam logic EIRQ_TYPE_LEVEL = 1'b0;
    localparam logic EIRQ_TYPE_EDGE  = 1'b1;
endpackage

// ### core/eirq_top.sv
/*
 * External interrupt flag logic for two inputs, with an APB register
 * slave, sticky event status and one masked interrupt output.
 * Assumes irq inputs and vector acknowledges are synchronous to pclk.
 */
module eirq_top (
    input  wire logic        pclk,             // Clock.
    input  wire logic        presetn,          // Async reset, active low.
    input  wire logic        psel,             // APB select.
    input  wire logic        penable,          // APB enable.
    input  wire logic        pwrite,           // APB write.
    input  wire logic [7:0]  paddr,            // APB byte address.
    input  wire logic [31:0] pwdata,           // APB write data.
    output logic      [31:0] prdata,           // APB read data.
    output logic             pready,           // APB ready.
    output logic             pslverr,          // APB error.
    input  wire logic        ext_irq_a_input,  // Irq a pin level.
    input  wire logic        ext_irq_b_input,  // Irq b pin level.
    input  wire logic        vector_ack_a,     // Core vectors to irq a.
    input  wire logic        vector_ack_b,     // Core vectors to irq b.
    output logic             ext_irq_a_pending,// Irq a pending flag.
    output logic             ext_irq_b_pending,// Irq b pending flag.
    output logic             irq               // Masked event interrupt.
);
    import eirq_pkg::*;

    // ========================================================
    // State.
    logic [7:0]  ctrl_ff,   nxt_ctrl;
    logic [1:0]  cfg_ff,    nxt_cfg;
    logic [1:0]  status_ff, nxt_status;
    logic [1:0]  mask_ff,   nxt_mask;
    logic [1:0]  prev_act_ff, nxt_prev_act;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic        irq_ff,    nxt_irq;

    logic        wr_en;
    logic        rd_en;
    logic [1:0]  act;
    logic [1:0]  detect;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == EIRQ_OFS_CTRL) || (a == EIRQ_OFS_CFG) ||
                   (a == EIRQ_OFS_STATUS) || (a == EIRQ_OFS_MASK);
    endfunction

    // Access phase completes in the second enable cycle; pready is a
    // registered answer so the access takes exactly two enable cycles.
    assign wr_en = psel && penable && pready_ff && pwrite;
    assign rd_en = psel && penable && pready_ff && !pwrite;

    // ========================================================
    // Detection: polarity bit sets the active level per input.
    assign act[0] = ext_irq_a_input ~^ cfg_ff[EIRQ_BIT_A_POL];
    assign act[1] = ext_irq_b_input ~^ cfg_ff[EIRQ_BIT_B_POL];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_det
            localparam int TB = (g == 0) ? EIRQ_BIT_A_TYPE : EIRQ_BIT_B_TYPE;
            // Level when type is 0, rising into active when type is 1.
            assign detect[g] = (ctrl_ff[TB] == EIRQ_TYPE_EDGE)
                               ? (act[g] && !prev_act_ff[g])
                               : act[g];
        end
    endgenerate

    // ========================================================
    // Next-state logic.
    always_comb begin
        nxt_ctrl     = ctrl_ff;
        nxt_cfg      = cfg_ff;
        nxt_mask     = mask_ff;
        nxt_status   = status_ff;
        nxt_prev_act = act;
        nxt_prdata   = 32'h0000_0000;
        nxt_pready   = psel && penable && !pready_ff;
        nxt_pslverr  = psel && penable && !pready_ff && !addr_hit(paddr);

        if (wr_en) begin
            unique case (paddr)
                EIRQ_OFS_CTRL:   nxt_ctrl = pwdata[7:0];
                EIRQ_OFS_CFG:    nxt_cfg  = pwdata[1:0];
                EIRQ_OFS_MASK:   nxt_mask = pwdata[1:0];
                default:         nxt_ctrl = ctrl_ff;
            endcase
        end
        if (psel && penable && !pready_ff && !pwrite) begin
            unique case (paddr)
                EIRQ_OFS_CTRL:   nxt_prdata = {24'h00_0000, ctrl_ff};
                EIRQ_OFS_CFG:    nxt_prdata = {30'h0, cfg_ff};
                EIRQ_OFS_STATUS: nxt_prdata = {30'h0, status_ff};
                EIRQ_OFS_MASK:   nxt_prdata = {30'h0, mask_ff};
                default:         nxt_prdata = 32'h0000_0000;
            endcase
        end
        // Status read clears; new events win over the clear.
        if (rd_en && paddr == EIRQ_OFS_STATUS) begin
            nxt_status = 2'h0;
        end

        // Vectoring clears the flag only in edge mode.
        if (vector_ack_b &&
            ctrl_ff[EIRQ_BIT_B_TYPE] == EIRQ_TYPE_EDGE) begin
            nxt_ctrl[EIRQ_BIT_B_PEND] = 1'b0;
        end
        if (vector_ack_a &&
            ctrl_ff[EIRQ_BIT_A_TYPE] == EIRQ_TYPE_EDGE) begin
            nxt_ctrl[EIRQ_BIT_A_PEND] = 1'b0;
        end

        // Hardware set wins over software or vector clear.
        if (detect[1]) begin
            nxt_ctrl[EIRQ_BIT_B_PEND] = 1'b1;
            nxt_status[EIRQ_EV_B]     = 1'b1;
        end
        if (detect[0]) begin
            nxt_ctrl[EIRQ_BIT_A_PEND] = 1'b1;
            nxt_status[EIRQ_EV_A]     = 1'b1;
        end

        nxt_irq = |(nxt_status & nxt_mask);
    end

    // ========================================================
    // Registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff     <= EIRQ_RST_CTRL;
            cfg_ff      <= EIRQ_RST_CFG;
            status_ff   <= 2'h0;
            mask_ff     <= EIRQ_RST_MASK;
            prev_act_ff <= 2'h0;
            prdata_ff   <= 32'h0000_0000;
            pready_ff   <= 1'b0;
            pslverr_ff  <= 1'b0;
            irq_ff      <= 1'b0;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            cfg_ff      <= nxt_cfg;
            status_ff   <= nxt_status;
            mask_ff     <= nxt_mask;
            prev_act_ff <= nxt_prev_act;
            prdata_ff   <= nxt_prdata;
            pready_ff   <= nxt_pready;
            pslverr_ff  <= nxt_pslverr;
            irq_ff      <= nxt_irq;
        end
    end

    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign irq               = irq_ff;
    assign ext_irq_a_pending = ctrl_ff[EIRQ_BIT_A_PEND];
    assign ext_irq_b_pending = ctrl_ff[EIRQ_BIT_B_PEND];
endmodule // eirq_top

// ### tb/eirq_chk.sv
/* Port checker for eirq_top.
   Bound to eirq_top; sees its ports only. */
module eirq_chk (
    input wire logic        pclk, presetn, psel, penable, // Clk, APB.
    input wire logic        pwrite, pready, irq,          // APB, irq.
    input wire logic [7:0]  paddr,                        // Address.
    input wire logic [31:0] pwdata,                       // Write data.
    input wire logic ext_irq_a_input, ext_irq_b_input,    // Pins.
    input wire logic vector_ack_a, vector_ack_b,          // Acks.
    input wire logic ext_irq_a_pending, ext_irq_b_pending // Flags.
);
    timeunit 1ns;
    timeprecision 1ns;
    import eirq_pkg::*;
    // Shadow: bit0/1 type a/b, bit2/3 polarity a/b.
    logic [3:0] cfg_ff;
    logic       wr, aa, ab;
    assign wr = psel & penable & pready & pwrite;
    assign aa = ext_irq_a_input == cfg_ff[2];
    assign ab = ext_irq_b_input == cfg_ff[3];
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) cfg_ff <= 4'h0;
        else if (wr && paddr == EIRQ_OFS_CTRL)
            cfg_ff[1:0] <= {pwdata[2], pwdata[0]};
        else if (wr && paddr == EIRQ_OFS_CFG) cfg_ff[3:2] <= pwdata[1:0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_lvl_a; !cfg_ff[0] && aa |=> ext_irq_a_pending; endproperty
    a_lvl_a: assert property (p_lvl_a) else $error("a level");
    property p_lvl_b; !cfg_ff[1] && ab |=> ext_irq_b_pending; endproperty
    a_lvl_b: assert property (p_lvl_b) else $error("b level");
    property p_edg_a; cfg_ff[0] && aa && !$past(aa) |=> ext_irq_a_pending;
    endproperty
    a_edg_a: assert property (p_edg_a) else $error("a edge");
    property p_edg_b; cfg_ff[1] && ab && !$past(ab) |=> ext_irq_b_pending;
    endproperty
    a_edg_b: assert property (p_edg_b) else $error("b edge");
    property p_vec_a; cfg_ff[0] && vector_ack_a && !wr
        && !(aa && !$past(aa)) |=> !ext_irq_a_pending; endproperty
    a_vec_a: assert property (p_vec_a) else $error("a vector");
    property p_vec_b; cfg_ff[1] && vector_ack_b && !wr
        && !(ab && !$past(ab)) |=> !ext_irq_b_pending; endproperty
    a_vec_b: assert property (p_vec_b) else $error("b vector");
    property p_ign_b; !cfg_ff[1] && ext_irq_b_pending && vector_ack_b
        && !wr |=> ext_irq_b_pending; endproperty
    a_ign_b: assert property (p_ign_b) else $error("b ack");
    property p_pol_b; !ab && !ext_irq_b_pending && !wr
        |=> !ext_irq_b_pending; endproperty
    a_pol_b: assert property (p_pol_b) else $error("b idle");
    c_vec: cover property (cfg_ff[1] && ext_irq_b_pending && vector_ack_b);
    c_lvl: cover property (!cfg_ff[0] && ext_irq_a_pending);
    c_irq: cover property (irq);
endmodule // eirq_chk
bind eirq_top eirq_chk u_chk (.*);

// ### tb/eirq_core_mdl.sv
/* Core model: vectors to a pending irq while enabled.
   Needs pending flags from eirq_top. */
module eirq_core_mdl (
    input wire logic pclk, presetn, en_a, en_b, // Clock, enables.
    input wire logic pend_a, pend_b,            // Pending flags.
    output logic     ack_a, ack_b               // Vector pulses.
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) {ack_a, ack_b} <= 2'h0;
        else {ack_a, ack_b} <= {en_a & pend_a & !ack_a,
                                en_b & pend_b & !ack_b};
endmodule // eirq_core_mdl

// ### tb/tb_eirq_top.sv
/* Self-checking bench for eirq_top.
   Needs eirq_core_mdl and the bound eirq_chk. */
module tb_eirq_top;
    timeunit 1ns;
    timeprecision 1ns;
    import eirq_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, in_a = 1, in_b = 1, en_a = 0, en_b = 0;
    logic ack_a, ack_b, pend_a, pend_b, irq;
    int n_mismatch = 0, checks = 0;
    eirq_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ext_irq_a_input(in_a),
        .ext_irq_b_input(in_b), .vector_ack_a(ack_a),
        .vector_ack_b(ack_b), .ext_irq_a_pending(pend_a),
        .ext_irq_b_pending(pend_b), .irq);
    eirq_core_mdl core (.pclk, .presetn, .en_a, .en_b, .pend_a, .pend_b,
        .ack_a, .ack_b);
    initial forever #20 pclk = ~pclk;
    task automatic stop_test;
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer, started an edge after the last one ended.
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20 && pready !== 1; i++) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        if (i == 20) begin
            n_mismatch++;
            stop_test;
        end
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] exp);
        apb(0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic t_reset;
        rdc("ctrl", EIRQ_OFS_CTRL, {24'h0, EIRQ_RST_CTRL});
        rdc("cfg", EIRQ_OFS_CFG, {30'h0, EIRQ_RST_CFG});
        rdc("mask", EIRQ_OFS_MASK, {30'h0, EIRQ_RST_MASK});
        rdc("hole", 8'h10, 32'h0);
        chk("slverr", 1, err);
    endtask
    task automatic t_level_b;
        in_b <= 0;
        apb(1, EIRQ_OFS_CFG, 32'h2);
        in_b <= 1;
        tick(2);
        chk("lvl b", 1, pend_b);
        in_b <= 0;
        en_b <= 1;
        tick(4);
        chk("ack ign", 1, pend_b);
        {en_b, in_b} <= 2'h0;
        apb(1, EIRQ_OFS_CTRL, 32'h0);
        tick(2);
        chk("idle b", 0, pend_b);
    endtask
    task automatic t_edge_a;
        apb(1, EIRQ_OFS_CTRL, 32'h1);
        in_a <= 0;
        tick(2);
        chk("edge a", 1, pend_a);
        en_a <= 1;
        tick(3);
        chk("vec a", 0, pend_a);
        {en_a, in_a} <= 2'h1;
    endtask
    task automatic t_irq;
        apb(1, EIRQ_OFS_CTRL, 32'h4);
        in_a <= 0;
        tick(2);
        chk("lvl a", 1, pend_a);
        in_a <= 1;
        apb(0, EIRQ_OFS_STATUS, 32'h0);
        apb(1, EIRQ_OFS_MASK, 32'h2);
        in_b <= 1;
        tick(2);
        chk("edge b", 1, pend_b);
        chk("irq", 1, irq);
        rdc("status", EIRQ_OFS_STATUS, 32'h2);
        tick(2);
        chk("irq clr", 0, irq);
        en_b <= 1;
        tick(3);
        chk("vec b", 0, pend_b);
    endtask
    task automatic t_pol_a;
        en_b <= 0;
        apb(1, EIRQ_OFS_CTRL, 32'h0);
        tick(1);
        chk("idle a", 0, pend_a);
        apb(1, EIRQ_OFS_CFG, 32'h3);
        apb(1, EIRQ_OFS_MASK, 32'h1);
        tick(1);
        chk("pol a", 1, pend_a);
        chk("irq a", 1, irq);
    endtask
    initial begin
        tick(5);
        presetn <= 1;
        t_reset;
        t_level_b;
        t_edge_a;
        t_irq;
        t_pol_a;
        stop_test;
    end
endmodule // tb_eirq_top
